// file: pwr_ctrl_pkg.sv
// Constants and types of the port power and reset controller
package pwr_ctrl_pkg;
  localparam int unsigned NPORT = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_RST   = 8'h04;
  localparam logic [7:0] OFS_STRAP = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0C;
  localparam logic [7:0] OFS_EVT   = 8'h10;
  // Reset register write-one bits
  localparam int unsigned RST_CORE_HARD = 0;
  localparam int unsigned RST_CORE_SOFT = 4;
  localparam int unsigned RST_CHIP_SOFT = 8;
  localparam int unsigned RST_PORT_HARD = 9;
  localparam int unsigned RST_PORT_SOFT = 10;
  // Status and event register fields
  localparam int unsigned STAT_STATE  = 0;
  localparam int unsigned STAT_ENERGY = 3;
  localparam int unsigned STAT_LOWPWR = 4;
  localparam int unsigned STAT_PLLOFF = 5;
  localparam int unsigned STAT_COMA   = 6;
  localparam int unsigned STAT_SHORT  = 7;
  localparam int unsigned EVT_ENERGY  = 0;
  // Mode-select strap patterns
  localparam logic [3:0] STRAP_SPD_HI  = 4'h4;
  localparam logic [4:0] STRAP_PLL_OFF = 5'h09;
  // Idle cycles before low power, and link pulse spacing, per code
  localparam logic [11:0] MASK_IVL [4] = '{12'h0FF, 12'h1FF, 12'h3FF, 12'h7FF};
  localparam logic [11:0] PULSE_IVL [4] = '{12'h200, 12'h400, 12'h800, 12'hC00};
  localparam logic [7:0]  LFSR_SEED = 8'h00;

  typedef struct packed {
    logic       pair_one;
    logic [1:0] pair_sel;
    logic       rand_dis;
    logic [1:0] pulse_t;
    logic [1:0] mask_t;
    logic       force_gig;
    logic       edp_pll_off;
    logic       edpd_en;
    logic       crystal_off_bit;
    logic       spd_pll_dis;
    logic       gate_ovr;
    logic       port_isolate_bit;
    logic       spd;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = '0;

  typedef struct packed {
    logic pll_en_mode;
    logic pll_dis_mode;
  } strap_ovr_t;

  typedef enum logic [2:0] {ST_INIT, ST_RUN, ST_EDPD, ST_SPD, ST_DEAD} state_t;

  typedef struct packed {
    logic             core_en;
    logic             data_en;
    logic             rclk_en;
    logic             led_en;
    logic             irq_en;
    logic             link_ok;
    logic             tx_en;
    logic             rx_en;
    logic             edet_en;
    logic             adc_low_res;
    logic             pll_en;
    logic             xtal_en;
    logic             fast_clk_en;
    logic             txrx_clk_en;
    logic             std_acc;
    logic             mmd_acc;
    logic             mmd1_acc;
    logic             link_pulse;
    logic [NPORT-1:0] pair_mask;
    logic [NPORT-1:0] core_rst;
    logic             chip_rst;
    logic             port_rst;
  } pwr_out_t;
endpackage

// file: pwr_ctrl.sv
// Power state, power-down and reset control of the four-port copper transceiver
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
module pwr_ctrl
  import pwr_ctrl_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_suspend,
  input  wire logic        i_pin_rst_n,
  input  wire logic [4:0]  i_strap_mode,
  input  wire logic [3:0]  i_energy,
  input  wire logic        i_cable_short,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output pwr_out_t         o_pwr
);

  typedef struct packed {
    state_t      state;
    ctrl_t       ctrl;
    strap_ovr_t  strap;
    logic        evt;
    logic        energy;
    logic        pll_off;
    logic [11:0] mask_cnt;
    logic [11:0] pulse_cnt;
    logic [7:0]  lfsr;
    logic        susp_s1;
    logic        susp_s2;
    logic        pin_s1;
    logic        pin_s2;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    pwr_out_t    out;
  } st_t;

  st_t s;
  st_t next_s;
  logic [3:0] pair_mask;
  logic       energy_now;
  logic       acc;

  // Strap-derived register defaults; power-down comes back if either bit is set
  function automatic ctrl_t dflt(input strap_ovr_t so);
    ctrl_t c;
    c             = CTRL_RST;
    c.spd         = so.pll_dis_mode | so.pll_en_mode;
    c.spd_pll_dis = so.pll_dis_mode;
    return c;
  endfunction

  // Pairs watched for energy
  always_comb begin
    if (!s.ctrl.force_gig) begin
      pair_mask = 4'h3;
    end else if (s.ctrl.pair_one) begin
      pair_mask = 4'h1 << s.ctrl.pair_sel;
    end else begin
      pair_mask = 4'hF;
    end
  end
  assign energy_now = |(i_energy & pair_mask);
  assign acc        = i_psel & i_penable & s.pready;

  // Next state of the whole block
  always_comb begin
    logic        dev_rst;
    logic        wake;
    logic [11:0] tgt;
    logic        coma;
    logic        run;
    logic        edpd;
    logic        spd;
    dev_rst = 1'b0;
    wake    = 1'b0;
    tgt     = 12'h000;
    coma    = 1'b0;
    run     = 1'b0;
    edpd    = 1'b0;
    spd     = 1'b0;
    next_s  = s;
    // Two-stage synchronisers
    next_s.susp_s1 = i_suspend;
    next_s.susp_s2 = s.susp_s1;
    next_s.pin_s1  = i_pin_rst_n;
    next_s.pin_s2  = s.pin_s1;
    next_s.lfsr    = {s.lfsr[6:0], ~(s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3])};
    next_s.out.core_rst   = '0;
    next_s.out.chip_rst   = 1'b0;
    next_s.out.port_rst   = 1'b0;
    next_s.out.link_pulse = 1'b0;

    // APB: answer in the first access cycle, data latched at setup
    next_s.pready  = i_psel & ~i_penable;
    next_s.pslverr = 1'b0;
    next_s.prdata  = 32'h0000_0000;
    if (i_psel && !i_penable) begin
      // Crystal stopped: nothing behind the port can answer
      if (s.state == ST_DEAD) begin
        next_s.pslverr = 1'b1;
      end else if (i_paddr == OFS_CTRL) begin
        next_s.prdata[15:0] = s.ctrl;
      end else if (i_paddr == OFS_RST) begin
        next_s.prdata = 32'h0000_0000;
      end else if (i_paddr == OFS_STRAP) begin
        next_s.prdata[1:0] = s.strap;
      end else if (i_paddr == OFS_STAT) begin
        next_s.prdata[STAT_STATE +: 3] = s.state;
        next_s.prdata[STAT_ENERGY]     = s.energy;
        next_s.prdata[STAT_LOWPWR]     = (s.state == ST_EDPD);
        next_s.prdata[STAT_PLLOFF]     = s.pll_off;
        next_s.prdata[STAT_COMA]       = s.susp_s2;
        next_s.prdata[STAT_SHORT]      = i_cable_short;
      end else if (i_paddr == OFS_EVT) begin
        next_s.prdata[EVT_ENERGY] = s.evt;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    // Writes take effect at the edge that completes the access
    if (acc && i_pwrite && !s.pslverr) begin
      if (i_paddr == OFS_CTRL) begin
        next_s.ctrl = ctrl_t'(i_pwdata[15:0]);
      end else if (i_paddr == OFS_RST) begin
        // Only the core bits reach the port cores
        next_s.out.core_rst = i_pwdata[RST_CORE_HARD +: NPORT] | i_pwdata[RST_CORE_SOFT +: NPORT];
        next_s.out.chip_rst = i_pwdata[RST_CHIP_SOFT];
        next_s.out.port_rst = i_pwdata[RST_PORT_HARD] | i_pwdata[RST_PORT_SOFT];
      end else if (i_paddr == OFS_STRAP) begin
        next_s.strap = strap_ovr_t'(i_pwdata[1:0]);
      end else if (i_paddr == OFS_EVT) begin
        if (i_pwdata[EVT_ENERGY]) begin
          next_s.evt = 1'b0;
        end
      end
    end

    // Power state machine
    case (s.state)
      ST_INIT: begin
        // Straps caught after release, then defaults follow them
        if (s.pin_s2) begin
          next_s.strap.pll_dis_mode = (i_strap_mode == STRAP_PLL_OFF);
          next_s.strap.pll_en_mode  = (i_strap_mode[4:1] == STRAP_SPD_HI) & ~i_strap_mode[0];
          next_s.ctrl  = dflt(next_s.strap);
          next_s.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (s.ctrl.spd) begin
          next_s.state   = ST_SPD;
          next_s.pll_off = s.ctrl.spd_pll_dis;
        end else if (s.ctrl.edpd_en && !energy_now) begin
          if (s.mask_cnt == MASK_IVL[s.ctrl.mask_t]) begin
            next_s.state     = ST_EDPD;
            next_s.mask_cnt  = 12'h000;
            next_s.pulse_cnt = 12'h000;
          end else begin
            next_s.mask_cnt = s.mask_cnt + 12'h001;
          end
        end else begin
          next_s.mask_cnt = 12'h000;
        end
      end
      ST_EDPD: begin
        wake           = energy_now | ~s.ctrl.edpd_en | s.ctrl.spd;
        // Flag follows the bit each cycle, so a clear mid-sleep is seen at once
        next_s.pll_off = s.ctrl.edp_pll_off;
        if (s.pll_off && (wake || !s.ctrl.edp_pll_off)) begin
          dev_rst = 1'b1;
        end else if (wake) begin
          next_s.state = ST_RUN;
        end
        // Periodic pulses so a sleeping partner can still wake us
        tgt = PULSE_IVL[s.ctrl.pulse_t] + (s.ctrl.rand_dis ? 12'h000 : {6'h00, s.lfsr[5:0]});
        if (s.pulse_cnt >= tgt) begin
          next_s.pulse_cnt      = 12'h000;
          next_s.out.link_pulse = 1'b1;
        end else begin
          next_s.pulse_cnt = s.pulse_cnt + 12'h001;
        end
      end
      ST_SPD: begin
        // Crystal may stop only once the PLL is already down
        if (s.pll_off && s.ctrl.crystal_off_bit) begin
          next_s.state = ST_DEAD;
        end else if (s.pll_off && (!s.ctrl.spd || !s.ctrl.spd_pll_dis)) begin
          dev_rst = 1'b1;
        end else if (!s.ctrl.spd) begin
          next_s.state = ST_RUN;
        end
      end
      ST_DEAD: begin
        next_s.state = ST_DEAD;
      end
      default: begin
        next_s.state = ST_INIT;
      end
    endcase

    // Device reset: registers back to strap defaults, cores included
    if (dev_rst) begin
      // Strap override survives, so set bits send us back to power-down
      next_s.ctrl         = dflt(s.strap);
      next_s.state        = ST_RUN;
      next_s.pll_off      = 1'b0;
      next_s.evt          = 1'b0;
      next_s.mask_cnt     = 12'h000;
      next_s.out.chip_rst = 1'b1;
      next_s.out.core_rst = '1;
    end

    // Energy change flag; a new change beats a same-cycle clear
    next_s.energy = energy_now;
    if (s.state != ST_INIT && energy_now != s.energy) begin
      next_s.evt = 1'b1;
    end

    // Level outputs from the present state
    coma = s.susp_s2;
    run  = (s.state == ST_RUN);
    edpd = (s.state == ST_EDPD);
    spd  = (s.state == ST_SPD);
    next_s.out.core_en     = ~coma & (run | edpd);
    next_s.out.data_en     = ~coma & run;
    next_s.out.rclk_en     = ~coma & run;
    next_s.out.led_en      = ~coma & run & ~s.ctrl.port_isolate_bit;
    next_s.out.irq_en      = ~coma & (run | edpd);
    next_s.out.link_ok     = ~coma & run & ~s.ctrl.edpd_en;
    next_s.out.tx_en       = run | edpd;
    next_s.out.rx_en       = run;
    next_s.out.edet_en     = run | edpd;
    next_s.out.adc_low_res = run & i_cable_short;
    next_s.out.pair_mask   = pair_mask;
    // PLL follows power state only; suspend never touches it
    next_s.out.pll_en      = (s.state != ST_INIT) & ~s.pll_off & (s.state != ST_DEAD);
    next_s.out.xtal_en     = (s.state != ST_DEAD);
    next_s.out.fast_clk_en = run | edpd | (spd & s.ctrl.gate_ovr);
    next_s.out.txrx_clk_en = run | edpd | (spd & s.ctrl.gate_ovr & ~s.ctrl.port_isolate_bit);
    next_s.out.std_acc     = (s.state != ST_DEAD);
    next_s.out.mmd_acc     = run | edpd | (spd & s.ctrl.gate_ovr);
    next_s.out.mmd1_acc    = run | edpd;

    // Pin reset held low: everything waits in init until it rises
    if (!s.pin_s2) begin
      next_s.state     = ST_INIT;
      next_s.ctrl      = CTRL_RST;
      next_s.strap     = '0;
      next_s.evt       = 1'b0;
      next_s.pll_off   = 1'b0;
      next_s.mask_cnt  = 12'h000;
      next_s.pulse_cnt = 12'h000;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_prdata  = s.prdata;
  assign o_pready  = s.pready;
  assign o_pslverr = s.pslverr;
  assign o_pwr     = s.out;

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  AST_COMA_DATA: assert property (s.susp_s2 |=> !o_pwr.data_en && !o_pwr.core_en)
    else $error("data or core active under suspend");
  AST_COMA_IND: assert property (s.susp_s2 |=> !o_pwr.led_en && !o_pwr.irq_en && !o_pwr.rclk_en)
    else $error("indication active under suspend");
  AST_COMA_PLL: assert property ($rose(s.susp_s2) && s.state == ST_RUN && !s.pll_off |=> o_pwr.pll_en)
    else $error("suspend stopped the PLL");
  AST_SHORT_TRIM: assert property (s.state == ST_RUN && i_cable_short |=> o_pwr.adc_low_res)
    else $error("short cable not trimmed");
  AST_EDPD_BLOCKS: assert property (s.state == ST_EDPD |=> !o_pwr.rx_en && o_pwr.tx_en && o_pwr.edet_en)
    else $error("wrong blocks in energy-detect power-down");
  AST_EDPD_OFF: assert property (s.state == ST_RUN && !s.ctrl.edpd_en |=> s.state != ST_EDPD)
    else $error("energy-detect entered while disabled");
  AST_EVT_SET: assert property (s.pin_s2 && s.state == ST_RUN && energy_now != s.energy |=> s.evt)
    else $error("energy change not flagged");
  AST_LINK_DOWN: assert property (s.ctrl.edpd_en |=> !o_pwr.link_ok)
    else $error("link up with energy-detect enabled");
  AST_EDPD_PLL: assert property (s.state == ST_EDPD && !s.ctrl.edp_pll_off ##1 s.state == ST_EDPD
                                 |=> o_pwr.pll_en)
    else $error("PLL stopped without disable bit");
  AST_SPD_ENTER: assert property (s.pin_s2 && s.state == ST_RUN && s.ctrl.spd |=> s.state == ST_SPD)
    else $error("power-down not entered");
  AST_SPD_MMD1: assert property (s.state == ST_SPD |=> !o_pwr.mmd1_acc)
    else $error("space one reachable in power-down");
  AST_SPD_CLK: assert property (s.state == ST_SPD && !(s.ctrl.gate_ovr && !s.ctrl.port_isolate_bit)
                                |=> !o_pwr.txrx_clk_en)
    else $error("TX/RX clocks run in power-down");
  AST_DEAD_HOLD: assert property (s.state == ST_DEAD && s.pin_s2 |=> s.state == ST_DEAD && !o_pwr.xtal_en)
    else $error("left crystal-off state without pin reset");
  AST_PIN_HOLD: assert property (!s.pin_s2 |=> s.state == ST_INIT ##1 !o_pwr.pll_en)
    else $error("pin reset not holding init");

  // Resets, power-down, suspend and pair selection
  AST_CORE_SPARE: assert property (acc && i_pwrite && !s.pslverr && i_paddr == OFS_RST
                                   && s.state == ST_RUN && s.pin_s2 && i_pwdata[7:0] == 8'h00 |=> o_pwr.core_rst == 4'h0)
    else $error("port core reset without a core reset bit");
  AST_DEV_RST: assert property (s.state == ST_EDPD && s.pll_off && energy_now && s.pin_s2
                                |=> o_pwr.core_rst == 4'hF && o_pwr.chip_rst && s.state == ST_RUN)
    else $error("no device reset on wake with PLL stopped");
  AST_STRAP_DIS: assert property (s.state == ST_INIT && s.pin_s2 && i_strap_mode == STRAP_PLL_OFF
                                  |=> s.strap.pll_dis_mode && s.ctrl.spd_pll_dis)
    else $error("PLL-off strap pattern not taken");
  AST_SPD_XTAL: assert property (s.state == ST_SPD |=> o_pwr.xtal_en && o_pwr.std_acc)
    else $error("crystal or standard access lost in power-down");
  AST_SPD_FAST: assert property (s.state == ST_SPD && !s.ctrl.gate_ovr |=> !o_pwr.fast_clk_en)
    else $error("fast clocks run in power-down");
  AST_SPD_PLL: assert property (s.state == ST_SPD && s.pll_off |=> !o_pwr.pll_en)
    else $error("PLL running with disable bit in power-down");
  AST_PULSE_ONLY: assert property (s.state != ST_EDPD |=> !o_pwr.link_pulse)
    else $error("link pulse outside energy-detect power-down");
  AST_PAIR_TWO: assert property (!s.ctrl.force_gig |=> o_pwr.pair_mask == 4'h3)
    else $error("wrong pairs watched without forced gigabit");
  AST_PAIR_ONE: assert property (s.ctrl.force_gig && s.ctrl.pair_one |=> $onehot(o_pwr.pair_mask))
    else $error("more than one pair watched in single-pair mode");
  AST_DEAD_ERR: assert property (i_psel && !i_penable && s.state == ST_DEAD |=> o_pready && o_pslverr)
    else $error("access answered without error in crystal-off state");
  AST_INIT_CTRL: assert property (!s.pin_s2 |=> s.ctrl == CTRL_RST && s.strap == '0)
    else $error("settings not cleared by pin reset");
  AST_COMA_LINK: assert property (s.susp_s2 |=> !o_pwr.link_ok)
    else $error("link shown under suspend");

  // Covers of the main scenarios
  CVR_EDPD: cover property (s.state == ST_RUN ##1 s.state == ST_EDPD);
  CVR_SPD_EXIT: cover property (s.state == ST_SPD ##1 s.state == ST_RUN);
  CVR_DEAD: cover property (s.state == ST_DEAD);
  CVR_DEV_RST: cover property (o_pwr.core_rst == 4'hF && o_pwr.chip_rst);
  CVR_COMA: cover property ($rose(s.susp_s2) ##1 !o_pwr.core_en);
endmodule

// file: host_model.sv
// Management host model that drives the register port
`timescale 1ns/1ns
module host_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_pready,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata
);
  // Idle bus at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'hFF;
    o_pwdata = 32'h0;
  end
  // One whole transfer, request held until ready is sampled high or 16 cycles pass
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    err = 1'b0;
    rdata = 32'h0;
    @(posedge i_clk_sys);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= addr;
    o_pwdata <= wdata;
    @(posedge i_clk_sys);
    o_penable <= 1'b1;
    for (n = 0; n < 16 && ok !== 1'b1; n++) begin
      @(posedge i_clk_sys);
      if (i_pready === 1'b1) begin
        ok = 1'b1;
        rdata = i_prdata;
        err = i_pslverr;
      end
    end
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released lines show no stale value
    o_paddr <= ~addr;
    o_pwdata <= ~wdata;
  endtask
endmodule

// file: tb.sv
// Self-checking bench of the port power and reset controller
`timescale 1ns/1ns
module tb
  import pwr_ctrl_pkg::*;
;
  logic        i_clk_sys, i_reset, psel, penable, pwrite, pready, pslverr;
  logic        i_suspend, i_pin_rst_n, i_cable_short, err, ok, seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v, v;
  logic [4:0]  strap;
  logic [3:0]  energy, core_or;
  pwr_out_t    pwr;
  int          n_mismatch, n_tests, n_dev_rst, n_chip, n_port, i, n0;

  pwr_ctrl dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_suspend(i_suspend),
    .i_pin_rst_n(i_pin_rst_n), .i_strap_mode(strap), .i_energy(energy),
    .i_cable_short(i_cable_short), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_pwr(pwr));
  host_model host (.i_clk_sys(i_clk_sys), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata));

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // Pulse counters; full core mask marks a whole-device reset
  always @(posedge i_clk_sys) begin
    if (pwr.core_rst === 4'hF) n_dev_rst <= n_dev_rst + 1;
    if (pwr.chip_rst === 1'b1) n_chip <= n_chip + 1;
    if (pwr.port_rst === 1'b1) n_port <= n_port + 1;
    core_or <= core_or | pwr.core_rst;
  end

  task automatic summarize();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // A hung transfer ends the run
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    host.xfer(wr, a, d, rd_v, err, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
  endtask
  // Write, then let the output flops settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    cyc(3);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask
  // Poll the state field under a bound
  task automatic wait_state(input logic [2:0] s);
    int n;
    for (n = 0; n < 1500; n++) begin
      bus(1'b0, OFS_STAT, 32'h0);
      if (rd_v[2:0] === s) return;
    end
    chk(rd_v[2:0], s);
    summarize();
  endtask

  initial begin
    i_reset = 1'b1;
    i_suspend = 1'b0;
    i_pin_rst_n = 1'b0;
    i_cable_short = 1'b0;
    strap = 5'h00;
    energy = 4'h0;
    core_or = 4'h0;
    n_mismatch = 0;
    n_tests = 0;
    n_dev_rst = 0;
    n_chip = 0;
    n_port = 0;
    v = $urandom(32'h5042);
    cyc(12);
    i_reset <= 1'b0;
    i_pin_rst_n <= 1'b1;
    wait_state(ST_RUN);
    rdchk(OFS_CTRL, 32'h0);
    $display("test start done");
    // Random tuning fields read back; power bits kept clear
    for (i = 0; i < 6; i++) begin
      v = $urandom() & 32'h0000FFC6;
      wr(OFS_CTRL, v);
      rdchk(OFS_CTRL, v);
    end
    wr(OFS_CTRL, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1);
    chk(rd_v, 32'h0);
    $display("test fields done");
    n0 = n_chip;
    wr(OFS_RST, 32'h00000700);
    chk(core_or, 4'h0);
    chk(n_chip, n0 + 1);
    chk(n_port, 1);
    wr(OFS_RST, 32'h00000005);
    chk(core_or, 4'h5);
    wr(OFS_RST, 32'h000000A0);
    chk(core_or, 4'hF);
    $display("test resets done");
    i_cable_short <= 1'b1;
    cyc(3);
    chk(pwr.adc_low_res, 1'b1);
    i_cable_short <= 1'b0;
    i_suspend <= 1'b1;
    cyc(1);
    chk(pwr.core_en, 1'b1);
    cyc(3);
    chk({pwr.core_en, pwr.data_en, pwr.rclk_en, pwr.led_en, pwr.irq_en}, 5'h00);
    chk({pwr.pll_en, pwr.std_acc, pwr.xtal_en}, 3'b111);
    i_suspend <= 1'b0;
    cyc(4);
    chk(pwr.core_en, 1'b1);
    $display("test suspend done");
    wr(OFS_CTRL, 32'h00000020);
    chk({pwr.link_ok, pwr.pair_mask}, 5'h03);
    wait_state(ST_EDPD);
    chk({pwr.tx_en, pwr.rx_en, pwr.edet_en, pwr.pll_en}, 4'b1011);
    seen = 1'b0;
    for (i = 0; i < 4000 && seen !== 1'b1; i++) begin
      @(posedge i_clk_sys);
      if (pwr.link_pulse === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b1);
    wr(OFS_CTRL, 32'h000000A0);
    chk(pwr.pair_mask, 4'hF);
    wr(OFS_CTRL, 32'h0000C0A0);
    chk(pwr.pair_mask, 4'h4);
    wr(OFS_CTRL, 32'h00000020);
    energy <= 4'h1;
    cyc(3);
    rdchk(OFS_EVT, 32'h1);
    wr(OFS_EVT, 32'h1);
    rdchk(OFS_EVT, 32'h0);
    wait_state(ST_RUN);
    rdchk(OFS_CTRL, 32'h00000020);
    $display("test energy done");
    energy <= 4'h0;
    wr(OFS_CTRL, 32'h00000060);
    wait_state(ST_EDPD);
    // PLL flag lags state entry by a cycle, output by one more
    cyc(2);
    chk(pwr.pll_en, 1'b0);
    n0 = n_dev_rst;
    energy <= 4'h2;
    wait_state(ST_RUN);
    chk(n_dev_rst, n0 + 1);
    rdchk(OFS_CTRL, 32'h0);
    $display("test energy pll done");
    wr(OFS_CTRL, 32'h00000001);
    wait_state(ST_SPD);
    chk({pwr.xtal_en, pwr.pll_en, pwr.fast_clk_en, pwr.txrx_clk_en}, 4'b1100);
    chk({pwr.std_acc, pwr.mmd_acc, pwr.mmd1_acc}, 3'b100);
    wr(OFS_CTRL, 32'h00000005);
    chk({pwr.fast_clk_en, pwr.txrx_clk_en, pwr.mmd_acc, pwr.mmd1_acc}, 4'b1110);
    wr(OFS_CTRL, 32'h00000007);
    chk(pwr.txrx_clk_en, 1'b0);
    n0 = n_dev_rst;
    wr(OFS_CTRL, 32'h00000006);
    wait_state(ST_RUN);
    rdchk(OFS_CTRL, 32'h00000006);
    chk(n_dev_rst, n0);
    $display("test power-down done");
    wr(OFS_CTRL, 32'h00000008);
    wr(OFS_CTRL, 32'h00000009);
    wait_state(ST_SPD);
    chk(pwr.pll_en, 1'b0);
    wr(OFS_CTRL, 32'h00000008);
    wait_state(ST_RUN);
    chk(n_dev_rst, n0 + 1);
    rdchk(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h00000008);
    wr(OFS_CTRL, 32'h00000009);
    wait_state(ST_SPD);
    wr(OFS_CTRL, 32'h00000019);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(err, 1'b1);
    chk({pwr.xtal_en, pwr.std_acc}, 2'b00);
    // Straps chosen for power-down with the PLL stopped
    strap <= 5'h09;
    i_pin_rst_n <= 1'b0;
    cyc(4);
    // Pair B still carries energy, so only that status bit stands
    rdchk(OFS_STAT, 32'h00000008);
    i_pin_rst_n <= 1'b1;
    wait_state(ST_SPD);
    chk(pwr.pll_en, 1'b0);
    rdchk(OFS_CTRL, 32'h00000009);
    rdchk(OFS_STRAP, 32'h1);
    wr(OFS_STRAP, 32'h0);
    wr(OFS_CTRL, 32'h0);
    wait_state(ST_RUN);
    rdchk(OFS_CTRL, 32'h0);
    // Straps chosen for power-down with the PLL kept running
    strap <= 5'h08;
    i_pin_rst_n <= 1'b0;
    cyc(4);
    i_pin_rst_n <= 1'b1;
    wait_state(ST_SPD);
    chk(pwr.pll_en, 1'b1);
    rdchk(OFS_STRAP, 32'h2);
    n0 = n_dev_rst;
    wr(OFS_CTRL, 32'h0);
    wait_state(ST_RUN);
    chk(n_dev_rst, n0);
    $display("test crystal and straps done");
    summarize();
  end
endmodule
